// ---- evr_defines.svh ----
// Register offsets, field positions and reset values of the event router
`ifndef EVR_DEFINES_SVH
`define EVR_DEFINES_SVH
`define EVR_NUM_SIG 105
`define EVR_NUM_OUT 5
`define EVR_NUM_BANK 4
// Byte offsets; each bank register is one word, bank n at base + 4*n
`define EVR_OFS_RAW 12'h000
`define EVR_OFS_PEND 12'h010
`define EVR_OFS_GEN 12'h020
`define EVR_OFS_TYPE0 12'h030
`define EVR_OFS_TYPE1 12'h040
`define EVR_OFS_OUT_STAT 12'h050
`define EVR_OFS_IRQ_STAT 12'h054
`define EVR_OFS_IRQ_MASK 12'h058
`define EVR_OFS_OMASK 12'h100
`define EVR_OFS_OPEND 12'h200
`define EVR_OUT_STRIDE 12'h010
`define EVR_RST_MASK 32'h0000_0000
`define EVR_RST_TYPE 32'h0000_0000
`define EVR_WAKE_OUT 4
`endif

// ---- evr_pkg.sv ----
// Types shared by the event router files
package evr_pkg;
	// Detection type encoding: {type1, type0}
	typedef enum logic [1:0] {
		EVR_HIGH = 2'h0,
		EVR_LOW = 2'h1,
		EVR_RISE = 2'h2,
		EVR_FALL = 2'h3
	} evr_sense_e;
	typedef struct packed {
		logic [11:0] addr;
		logic wr;
		logic rd;
		logic [31:0] wdata;
	} evr_req_s;
	typedef enum logic [1:0] {
		EVR_IDLE = 2'b01,
		EVR_DONE = 2'b10
	} evr_bus_e;
endpackage

// ---- evr_sync.sv ----
// Two-flop synchroniser bank for the monitored inputs
`timescale 1ns/1ps
module evr_sync import evr_pkg::*; #(
	parameter int WIDTH = 105
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// ---- evr_slice.sv ----
// One detection slice: polarity, level or edge, sticky edge capture
`timescale 1ns/1ps
module evr_slice import evr_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sig_in,
	input wire logic [1:0] sense,
	input wire logic clr,
	output logic raw
);
	logic prev_r;
	logic edge_r;
	logic hit;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= sig_in;
		end
	end
	always_comb begin
		hit = 1'b0;
		unique case (evr_sense_e'(sense))
			EVR_RISE: hit = sig_in & ~prev_r;
			EVR_FALL: hit = ~sig_in & prev_r;
			default: hit = 1'b0;
		endcase
	end
	// A new edge in the clearing cycle survives the clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			edge_r <= 1'b0;
		end else if (hit) begin
			edge_r <= 1'b1;
		end else if (clr || !sense[1]) begin
			edge_r <= 1'b0;
		end
	end
	always_comb begin
		unique case (evr_sense_e'(sense))
			EVR_HIGH: raw = sig_in;
			EVR_LOW: raw = ~sig_in;
			default: raw = edge_r;
		endcase
	end
endmodule

// ---- evr_router.sv ----
// Event router top: detection, global enable, five output blocks, Avalon-MM slave
`timescale 1ns/1ps
`include "evr_defines.svh"
module evr_router import evr_pkg::*; #(
	parameter int NSIG = `EVR_NUM_SIG,
	parameter int NOUT = `EVR_NUM_OUT
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [NSIG-1:0] event_in,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [3:0] intc_req,
	output logic clock_generation_unit_wake,
	output logic irq
);
	localparam int NW = `EVR_NUM_BANK * 32;

	logic [NSIG-1:0] sync_sig;
	logic [NSIG-1:0] raw;
	logic [NSIG-1:0] pend;
	logic [NW-1:0] gen_r;
	logic [NW-1:0] type0_r;
	logic [NW-1:0] type1_r;
	logic [NW-1:0] omask_r [NOUT];
	logic [NSIG-1:0] opend [NOUT];
	logic [NOUT-1:0] out_stat;
	logic [NOUT-1:0] out_prev_r;
	logic [NOUT-1:0] irq_stat_r;
	logic [NOUT-1:0] irq_mask_r;
	logic [NW-1:0] raw_clr;
	logic [NW-1:0] raw_w;
	logic [NW-1:0] pend_w;
	evr_req_s req;
	evr_bus_e bus_r;
	logic [31:0] wmask;
	logic take;

	assign req = '{addr: avs_address, wr: avs_write, rd: avs_read, wdata: avs_writedata};

	// Synchronising every input costs two cycles of latency even on internal strobes
	evr_sync #(.WIDTH(NSIG)) u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in(event_in),
		.sync_out(sync_sig)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NSIG; gi++) begin : g_slice
			evr_slice u_slice (
				.sys_clk(sys_clk),
				.reset_n(reset_n),
				.sig_in(sync_sig[gi]),
				.sense({type1_r[gi], type0_r[gi]}),
				.clr(raw_clr[gi]),
				.raw(raw[gi])
			);
		end
	endgenerate

	assign pend = raw & gen_r[NSIG-1:0];

	generate
		for (gi = 0; gi < NOUT; gi++) begin : g_out
			assign opend[gi] = pend & omask_r[gi][NSIG-1:0];
			assign out_stat[gi] = |opend[gi];
			chk_out_each: assert property (@(posedge sys_clk) disable iff (!reset_n)
				out_stat[gi] == |(raw & gen_r[NSIG-1:0] & omask_r[gi][NSIG-1:0]))
				else $error("output block not OR of masked raw");
		end
	endgenerate

	assign intc_req = out_stat[3:0];
	assign clock_generation_unit_wake = out_stat[`EVR_WAKE_OUT];

	// Bank index from a byte address inside a four-word block
	function automatic logic [1:0] bank_of(input logic [11:0] a);
		bank_of = a[3:2];
	endfunction

	function automatic logic hit_blk(input logic [11:0] a, input logic [11:0] base);
		hit_blk = (a[11:4] == base[11:4]);
	endfunction

	// Register that the four words together hold NW bits, padded above NSIG
	function automatic logic [31:0] word_of(input logic [NW-1:0] v, input logic [1:0] b);
		word_of = v[b*32 +: 32];
	endfunction

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
		end
	end

	// One wait cycle on every access gives registered read data
	assign take = (avs_read || avs_write) && (bus_r == EVR_IDLE);
	assign avs_waitrequest = (avs_read || avs_write) && (bus_r == EVR_IDLE);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_r <= EVR_IDLE;
		end else begin
			unique case (bus_r)
				EVR_IDLE: if (take) bus_r <= EVR_DONE;
				EVR_DONE: bus_r <= EVR_IDLE;
			endcase
		end
	end

	always_comb begin
		raw_clr = '0;
		if (take && req.wr && hit_blk(req.addr, `EVR_OFS_RAW)) begin
			raw_clr[bank_of(req.addr)*32 +: 32] = req.wdata & wmask;
		end
	end

	// Writable configuration: global enable, detection type, per-output masks
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			gen_r <= {`EVR_NUM_BANK{`EVR_RST_MASK}};
			type0_r <= {`EVR_NUM_BANK{`EVR_RST_TYPE}};
			type1_r <= {`EVR_NUM_BANK{`EVR_RST_TYPE}};
		end else if (take && req.wr) begin
			if (hit_blk(req.addr, `EVR_OFS_GEN)) begin
				gen_r[bank_of(req.addr)*32 +: 32] <=
					(word_of(gen_r, bank_of(req.addr)) & ~wmask) | (req.wdata & wmask);
			end
			if (hit_blk(req.addr, `EVR_OFS_TYPE0)) begin
				type0_r[bank_of(req.addr)*32 +: 32] <=
					(word_of(type0_r, bank_of(req.addr)) & ~wmask) | (req.wdata & wmask);
			end
			if (hit_blk(req.addr, `EVR_OFS_TYPE1)) begin
				type1_r[bank_of(req.addr)*32 +: 32] <=
					(word_of(type1_r, bank_of(req.addr)) & ~wmask) | (req.wdata & wmask);
			end
		end
	end

	generate
		for (gi = 0; gi < NOUT; gi++) begin : g_omask
			localparam logic [11:0] MBASE = 12'(`EVR_OFS_OMASK + gi * `EVR_OUT_STRIDE);
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					omask_r[gi] <= {`EVR_NUM_BANK{`EVR_RST_MASK}};
				end else if (take && req.wr && hit_blk(req.addr, MBASE)) begin
					omask_r[gi][bank_of(req.addr)*32 +: 32] <=
						(word_of(omask_r[gi], bank_of(req.addr)) & ~wmask)
						| (req.wdata & wmask);
				end
			end
		end
	endgenerate

	// Rising output edges are sticky interrupt events; a new event beats the clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_prev_r <= '0;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
		end else begin
			out_prev_r <= out_stat;
			if (take && req.wr && req.addr == `EVR_OFS_IRQ_STAT) begin
				irq_stat_r <= (irq_stat_r & ~(req.wdata[NOUT-1:0] & wmask[NOUT-1:0]))
					| (out_stat & ~out_prev_r);
			end else begin
				irq_stat_r <= irq_stat_r | (out_stat & ~out_prev_r);
			end
			if (take && req.wr && req.addr == `EVR_OFS_IRQ_MASK) begin
				irq_mask_r <= (irq_mask_r & ~wmask[NOUT-1:0])
					| (req.wdata[NOUT-1:0] & wmask[NOUT-1:0]);
			end
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	assign raw_w = NW'(raw);
	assign pend_w = NW'(pend);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (take && req.rd) begin
			avs_readdata <= 32'h0000_0000;
			if (hit_blk(req.addr, `EVR_OFS_RAW)) begin
				avs_readdata <= word_of(raw_w, bank_of(req.addr));
			end else if (hit_blk(req.addr, `EVR_OFS_PEND)) begin
				avs_readdata <= word_of(pend_w, bank_of(req.addr));
			end else if (hit_blk(req.addr, `EVR_OFS_GEN)) begin
				avs_readdata <= word_of(gen_r, bank_of(req.addr));
			end else if (hit_blk(req.addr, `EVR_OFS_TYPE0)) begin
				avs_readdata <= word_of(type0_r, bank_of(req.addr));
			end else if (hit_blk(req.addr, `EVR_OFS_TYPE1)) begin
				avs_readdata <= word_of(type1_r, bank_of(req.addr));
			end else if (req.addr == `EVR_OFS_OUT_STAT) begin
				avs_readdata <= 32'(out_stat);
			end else if (req.addr == `EVR_OFS_IRQ_STAT) begin
				avs_readdata <= 32'(irq_stat_r);
			end else if (req.addr == `EVR_OFS_IRQ_MASK) begin
				avs_readdata <= 32'(irq_mask_r);
			end else begin
				for (int o = 0; o < NOUT; o++) begin
					if (hit_blk(req.addr, 12'(`EVR_OFS_OMASK + o * `EVR_OUT_STRIDE))) begin
						avs_readdata <= word_of(omask_r[o], bank_of(req.addr));
					end
					if (hit_blk(req.addr, 12'(`EVR_OFS_OPEND + o * `EVR_OUT_STRIDE))) begin
						avs_readdata <= word_of(NW'(opend[o]), bank_of(req.addr));
					end
				end
			end
		end
	end

	chk_pend_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pend == (raw & gen_r[NSIG-1:0]))
		else $error("pending differs from enabled raw");
	chk_out_or: assert property (@(posedge sys_clk) disable iff (!reset_n)
		out_stat[0] == |(pend & omask_r[0][NSIG-1:0]))
		else $error("output 0 not OR of masked pending");
	chk_wake_route: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clock_generation_unit_wake == |(raw & gen_r[NSIG-1:0] & omask_r[4][NSIG-1:0]))
		else $error("wake output wrong");
	chk_intc_route: assert property (@(posedge sys_clk) disable iff (!reset_n)
		intc_req == out_stat[3:0])
		else $error("interrupt requests wrong");
	chk_sync_lat: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_sig[0] == $past(event_in[0], 2))
		else $error("sync latency not two");
	chk_level_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(type1_r[0] == 1'b0 && type0_r[0] == 1'b0) |-> raw[0] == sync_sig[0])
		else $error("high level raw wrong");
	chk_rise_latch: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(type1_r[64] && !type0_r[64] && $rose(sync_sig[64]) && $stable(type1_r[64])
		&& $stable(type0_r[64])) |=> raw[64])
		else $error("rising edge not latched");
	chk_read_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(avs_read && !avs_waitrequest && $past(avs_address) == `EVR_OFS_OUT_STAT
		&& $past(take)) |-> avs_readdata == 32'($past(out_stat)))
		else $error("output status read wrong");
	chk_opend_and: assert property (@(posedge sys_clk) disable iff (!reset_n)
		opend[1] == (pend & omask_r[1][NSIG-1:0]))
		else $error("output pending product wrong");

	// Bus handshake: one wait cycle per access, read data held between reads
	chk_bus_state: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(bus_r == EVR_IDLE) || (bus_r == EVR_DONE))
		else $error("bus state not one-hot");
	chk_wait_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
		((avs_read || avs_write) && !$past(take)) |-> avs_waitrequest)
		else $error("first cycle of an access not stalled");
	chk_wait_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$past(take) |-> !avs_waitrequest)
		else $error("second cycle of an access still stalled");
	chk_idle_nowait: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without a request");
	chk_rdata_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!$past(take && req.rd) |-> $stable(avs_readdata))
		else $error("read data moved without a read");

	// Read data of the taking edge is the register state at that edge
	chk_read_raw: assert property (@(posedge sys_clk) disable iff (!reset_n)
		($past(take && req.rd) && $past(avs_address) == `EVR_OFS_RAW)
		|-> avs_readdata == $past(raw[31:0]))
		else $error("raw status read wrong");
	chk_read_pend: assert property (@(posedge sys_clk) disable iff (!reset_n)
		($past(take && req.rd) && $past(avs_address) == `EVR_OFS_PEND)
		|-> avs_readdata == $past(pend[31:0]))
		else $error("pending read wrong");
	chk_read_opend: assert property (@(posedge sys_clk) disable iff (!reset_n)
		($past(take && req.rd) && $past(avs_address) == (`EVR_OFS_OPEND + `EVR_OUT_STRIDE))
		|-> avs_readdata == $past(opend[1][31:0]))
		else $error("output pending read wrong");
	chk_read_unmap: assert property (@(posedge sys_clk) disable iff (!reset_n)
		($past(take && req.rd) && $past(avs_address) == 12'h300)
		|-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// Writes land at the taking edge; disabled byte lanes keep their bits
	chk_gen_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
		($past(take && req.wr && (&avs_byteenable)) && $past(avs_address) == `EVR_OFS_GEN)
		|-> gen_r[31:0] == $past(avs_writedata))
		else $error("enable word write lost");
	chk_omask_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
		($past(take && req.wr && (&avs_byteenable)) && $past(avs_address) == `EVR_OFS_OMASK)
		|-> omask_r[0][31:0] == $past(avs_writedata))
		else $error("output mask write lost");
	chk_type_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
		($past(take && req.wr && (&avs_byteenable))
		&& $past(avs_address) == (`EVR_OFS_TYPE0 + 12'h008)) |-> type0_r[95:64] == $past(avs_writedata))
		else $error("type word write lost");
	chk_lane_keep: assert property (@(posedge sys_clk) disable iff (!reset_n)
		($past(take && req.wr && !avs_byteenable[0]) && $past(avs_address) == `EVR_OFS_TYPE1)
		|-> type1_r[7:0] == $past(type1_r[7:0]))
		else $error("disabled byte lane was written");

	// Sticky status: a rising output sets it, only a written one clears it
	chk_stat_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(|(out_stat & ~out_prev_r)) |=>
		((irq_stat_r & $past(out_stat & ~out_prev_r)) == $past(out_stat & ~out_prev_r)))
		else $error("rising output did not set its status bit");
	chk_stat_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(irq_stat_r[0]) |-> $past(take && req.wr && req.addr == `EVR_OFS_IRQ_STAT
		&& req.wdata[0] && avs_byteenable[0]))
		else $error("status bit fell without a written one");
	chk_irq_masked: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(irq_mask_r == '0) |-> !irq)
		else $error("interrupt raised with all sources masked");

	// Detection of a low level and the life of an edge latch
	chk_level_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(!type1_r[104] && type0_r[104]) |-> raw[104] == ~sync_sig[104])
		else $error("low level raw wrong");
	chk_fall_latch: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(type1_r[64] && type0_r[64] && $fell(sync_sig[64]) && $stable(type1_r[64])
		&& $stable(type0_r[64])) |=> raw[64])
		else $error("falling edge not latched");
	chk_edge_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		($past(raw[64]) && !$past(raw_clr[64]) && type1_r[64] && $stable(type1_r[64])
		&& $stable(type0_r[64])) |-> raw[64])
		else $error("edge latch dropped without a clear");
	chk_sync_all: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_sig == $past(event_in, 2))
		else $error("synchroniser latency not two on every signal");
endmodule

// ---- evr_far_model.sv ----
// Model of the interrupt controller and clock generation unit facing the router
`timescale 1ns/1ps
module evr_far_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [3:0] intc_req,
	input wire logic [3:0] intc_en,
	input wire logic clock_generation_unit_wake,
	output logic intc_irq,
	output logic wake_seen_r
);
	// Each request line raises the processor request only when enabled
	assign intc_irq = |(intc_req & intc_en);
	// Wake is level sensitive; the unit remembers that a wake-up was asked for
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_seen_r <= 1'b0;
		end else if (clock_generation_unit_wake) begin
			wake_seen_r <= 1'b1;
		end
	end
endmodule

// ---- tb_event_router.sv ----
// Self-checking bench for the event router
`timescale 1ns/1ps
`include "evr_defines.svh"
module tb_event_router;
	import evr_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [104:0] event_in = '0;
	logic [11:0] avs_address = 12'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] intc_req;
	logic [3:0] intc_en = 4'h0;
	logic wake;
	logic irq;
	logic intc_irq;
	logic wake_seen;
	logic [31:0] rd;
	int n_fail = 0;
	int cmp_count = 0;
	always #50 sys_clk = ~sys_clk;
	evr_router dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .event_in(event_in),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.intc_req(intc_req), .clock_generation_unit_wake(wake), .irq(irq));
	evr_far_model far_u (.sys_clk(sys_clk), .reset_n(reset_n), .intc_req(intc_req),
		.intc_en(intc_en), .clock_generation_unit_wake(wake), .intc_irq(intc_irq),
		.wake_seen_r(wake_seen));
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Waitrequest is read mid-cycle so the value seen is the one the next edge samples
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic wt;
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		do begin
			@(negedge sys_clk);
			wt = avs_waitrequest;
			rd = avs_readdata;
			@(posedge sys_clk);
		end while (wt !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic cmp_word(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		cmp_count++;
		if (rd !== exp) begin
			n_fail++;
			$display("unexpected at %0t: read %h gave %h not %h", $time, a, rd, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: output %b not %b", $time, got, exp);
		end
	endtask
	task automatic set_ev(input int idx, input logic v);
		@(posedge sys_clk);
		event_in[idx] <= v;
		repeat (5) @(posedge sys_clk);
	endtask
	initial begin
		#(100 * 20000);
		n_fail++;
		$display("unexpected at %0t: watchdog expired", $time);
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		cmp_word(`EVR_OFS_RAW, 32'h0);
		cmp_word(`EVR_OFS_OUT_STAT, 32'h0);
		cmp_word(12'h300, 32'h0);
		// Signal 0: high level, enabled, routed to output 0
		bus(1'b1, `EVR_OFS_GEN, 32'h1);
		bus(1'b1, `EVR_OFS_OMASK, 32'h1);
		@(posedge sys_clk);
		event_in[0] <= 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		cmp_bit(intc_req[0], 1'b0);
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		cmp_bit(intc_req[0], 1'b1);
		cmp_bit(intc_irq, 1'b0);
		intc_en <= 4'h1;
		@(negedge sys_clk);
		cmp_bit(intc_irq, 1'b1);
		cmp_word(`EVR_OFS_RAW, 32'h1);
		cmp_word(`EVR_OFS_PEND, 32'h1);
		cmp_word(`EVR_OFS_OPEND, 32'h1);
		cmp_word(`EVR_OFS_OPEND + `EVR_OUT_STRIDE, 32'h0);
		// Status is sticky, masked into irq and cleared by a written one
		cmp_word(`EVR_OFS_IRQ_STAT, 32'h1);
		@(negedge sys_clk);
		cmp_bit(irq, 1'b0);
		bus(1'b1, `EVR_OFS_IRQ_MASK, 32'h1);
		@(negedge sys_clk);
		cmp_bit(irq, 1'b1);
		bus(1'b1, `EVR_OFS_IRQ_STAT, 32'h1);
		@(negedge sys_clk);
		cmp_bit(irq, 1'b0);
		// Signal 33 detected but not enabled stays out of pending
		set_ev(33, 1'b1);
		cmp_word(`EVR_OFS_RAW + 12'h004, 32'h2);
		cmp_word(`EVR_OFS_PEND + 12'h004, 32'h0);
		// Signal 104: low level, enabled, routed to the wake output
		bus(1'b1, `EVR_OFS_TYPE0 + 12'h00c, 32'h100);
		bus(1'b1, `EVR_OFS_GEN + 12'h00c, 32'h100);
		bus(1'b1, `EVR_OFS_OMASK + 12'h04c, 32'h100);
		repeat (4) @(posedge sys_clk);
		cmp_word(`EVR_OFS_RAW + 12'h00c, 32'h100);
		cmp_word(`EVR_OFS_OPEND + 12'h04c, 32'h100);
		cmp_word(`EVR_OFS_OUT_STAT, 32'h11);
		@(negedge sys_clk);
		cmp_bit(wake_seen, 1'b1);
		set_ev(104, 1'b1);
		@(negedge sys_clk);
		cmp_bit(wake, 1'b0);
		// Signal 64: rising edge is held after the pulse until a one is written
		bus(1'b1, `EVR_OFS_TYPE1 + 12'h008, 32'h1);
		set_ev(64, 1'b1);
		set_ev(64, 1'b0);
		cmp_word(`EVR_OFS_RAW + 12'h008, 32'h1);
		bus(1'b1, `EVR_OFS_RAW + 12'h008, 32'h1);
		cmp_word(`EVR_OFS_RAW + 12'h008, 32'h0);
		// Falling edge ignores the rise and catches the fall
		bus(1'b1, `EVR_OFS_TYPE0 + 12'h008, 32'h1);
		set_ev(64, 1'b1);
		cmp_word(`EVR_OFS_RAW + 12'h008, 32'h0);
		set_ev(64, 1'b0);
		cmp_word(`EVR_OFS_RAW + 12'h008, 32'h1);
		// Only the enabled byte lane of a write lands
		avs_byteenable <= 4'h2;
		bus(1'b1, `EVR_OFS_TYPE1, 32'hffff_ffff);
		avs_byteenable <= 4'hf;
		cmp_word(`EVR_OFS_TYPE1, 32'h0000_ff00);
		print_verdict();
	end
endmodule
